// ==== verilog/rta_pkg.sv ====
package rta_pkg;

    // ****************************************************************
    // bus map
    // ****************************************************************
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFS_ALARM0      = 8'h1C;
    localparam logic [7:0]  OFS_ALARM1      = 8'h20;
    localparam logic [7:0]  OFS_KEY         = 8'h24;
    localparam logic [7:0]  OFS_SUBSEC      = 8'h28;
    localparam logic [7:0]  OFS_FLAGS       = 8'h40;
    localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h44;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h48;
    localparam logic [7:0]  OFS_LOCK_STATUS = 8'h4C;

    // ****************************************************************
    // alarm field layout
    // ****************************************************************
    localparam int DATE_MASK_BIT   = 31;
    localparam int WEEKDAY_SEL_BIT = 30;
    localparam int DAY_TENS_MSB    = 29;
    localparam int DAY_UNITS_MSB   = 27;
    localparam int DAY_UNITS_LSB   = 24;
    localparam int HOUR_MASK_BIT   = 23;
    localparam int MERIDIEM_BIT    = 22;
    localparam int HOUR_UNITS_LSB  = 16;
    localparam int MINUTE_MASK_BIT = 15;
    localparam int MINUTE_TENS_MSB = 14;
    localparam int MINUTE_UNITS_LSB = 8;
    localparam int SECOND_MASK_BIT = 7;
    localparam int SECOND_TENS_MSB = 6;
    localparam int SECOND_UNITS_LSB = 0;

    // ****************************************************************
    // widths, keys, reset values, event bits
    // ****************************************************************
    localparam int           KEY_W        = 8;
    localparam logic [7:0]   KEY_FIRST    = 8'hCA;
    localparam logic [7:0]   KEY_SECOND   = 8'h53;
    localparam int           SUBSEC_W     = 16;
    localparam int           FACTOR_W     = 15;
    localparam logic [31:0]  ALARM_RESET  = 32'h0000_0000;
    localparam logic [15:0]  SUBSEC_RESET = 16'h0000;
    localparam int           NUM_EVT      = 3;
    localparam int           EVT_ALARM0   = 0;
    localparam int           EVT_ALARM1   = 1;
    localparam int           EVT_REFUSED  = 2;

    typedef enum logic [1:0] {
        LOCK_CLOSED = 2'b00,
        LOCK_HALF   = 2'b01,
        LOCK_OPEN   = 2'b10
    } rta_lock_type;

endpackage : rta_pkg

// ==== verilog/rta_cal_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// current calendar time and its once-per-second update strobe
interface rta_cal_if;
    logic [22:0] time_now;     // meridiem, hour, minute, second in alarm layout
    logic [5:0]  day_now;      // day tens 5:4, day units 3:0
    logic [2:0]  weekday_now;
    logic        update;
    modport source (output time_now, output day_now, output weekday_now, output update);
    modport sink   (input time_now, input day_now, input weekday_now, input update);
endinterface : rta_cal_if
`default_nettype wire

// ==== verilog/rta_alarm_match.sv ====
`timescale 1ns/1ps
`default_nettype none
module rta_alarm_match
    import rta_pkg::*;
(
    input  wire logic [31:0] alarm_in,
    rta_cal_if.sink          cal,
    output logic             hit_out
);
    logic sec_ok;
    logic min_ok;
    logic hour_ok;
    logic date_ok;

    // each field passes when masked or equal
    assign sec_ok  = alarm_in[SECOND_MASK_BIT] ||
                     (alarm_in[SECOND_TENS_MSB:SECOND_UNITS_LSB] ==
                      cal.time_now[SECOND_TENS_MSB:SECOND_UNITS_LSB]);
    assign min_ok  = alarm_in[MINUTE_MASK_BIT] ||
                     (alarm_in[MINUTE_TENS_MSB:MINUTE_UNITS_LSB] ==
                      cal.time_now[MINUTE_TENS_MSB:MINUTE_UNITS_LSB]);
    // meridiem flag travels with the hour digits
    assign hour_ok = alarm_in[HOUR_MASK_BIT] ||
                     (alarm_in[MERIDIEM_BIT:HOUR_UNITS_LSB] ==
                      cal.time_now[MERIDIEM_BIT:HOUR_UNITS_LSB]);
    // weekday mode drops the tens digit entirely
    assign date_ok = alarm_in[DATE_MASK_BIT] ||
                     (alarm_in[WEEKDAY_SEL_BIT] ?
                      (alarm_in[DAY_UNITS_MSB:DAY_UNITS_LSB] == {1'b0, cal.weekday_now}) :
                      (alarm_in[DAY_TENS_MSB:DAY_UNITS_LSB] == cal.day_now));

    assign hit_out = sec_ok && min_ok && hour_ok && date_ok;
endmodule : rta_alarm_match
`default_nettype wire

// ==== verilog/rta_subsec.sv ====
`timescale 1ns/1ps
`default_nettype none
module rta_subsec
    import rta_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                bkp_rst_in,
    input  wire logic                sys_rst_in,
    input  wire logic                async_tick_in,
    input  wire logic                init_in,
    input  wire logic                bypass_in,
    input  wire logic [FACTOR_W-1:0] factor_in,
    output logic      [SUBSEC_W-1:0] value_out,
    output logic                     tick_out
);
    logic [SUBSEC_W-1:0] count;
    logic [SUBSEC_W-1:0] shadow;

    // down-counter lives in the backup domain; stops while initialising
    always_ff @(posedge clk_in or posedge bkp_rst_in) begin
        if (bkp_rst_in) begin
            count    <= SUBSEC_RESET;
            tick_out <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (async_tick_in && !init_in) begin
                if (count == SUBSEC_RESET) begin
                    count    <= {1'b0, factor_in};
                    tick_out <= 1'b1;
                end else begin
                    count <= count - 16'h0001;
                end
            end
        end
    end

    // shadow copy cleared by system reset, loaded with the pre-step count on every async tick, init or not
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            shadow <= SUBSEC_RESET;
        end else if (async_tick_in) begin
            shadow <= count;
        end
    end

    // bypass reads the live counter, which system reset leaves alone
    assign value_out = bypass_in ? count : shadow;
endmodule : rta_subsec
`default_nettype wire

// ==== verilog/rta_top.sv ====
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - alarm writes only in init state
// - date mask drops day from compare
// - hour mask drops hour and meridiem
// - minute mask drops minutes from compare
// - second mask drops seconds from compare
// - weekday select compares units as weekday
// - alarm fields hold BCD digits
// - meridiem flag compared with hour
// - backup reset clears alarms, system keeps
// - key register takes eight bits only
// - sub-second register shows prescaler counter
// - system reset zeroes sub-second unless bypass
// - prescaler divides by factor plus one
// - match sets flag, software writes zero
module rta_top
    import rta_pkg::*;
(
    input  wire logic                CLK_IN,
    input  wire logic                RST_IN,
    input  wire logic                BKP_RST_IN,
    input  wire logic [ADDR_W-1:0]   ADDR_IN,
    input  wire logic [31:0]         WDATA_IN,
    input  wire logic                WR_IN,
    input  wire logic                RD_IN,
    input  wire logic                INIT_STATE_IN,
    input  wire logic                SHADOW_BYPASS_IN,
    input  wire logic                ASYNC_TICK_IN,
    input  wire logic [FACTOR_W-1:0] SYNC_FACTOR_IN,
    input  wire logic [22:0]         CAL_TIME_IN,
    input  wire logic [5:0]          CAL_DAY_IN,
    input  wire logic [2:0]          CAL_WEEKDAY_IN,
    input  wire logic                CAL_UPDATE_IN,
    output logic      [31:0]         RDATA_OUT,
    output logic                     ONE_SECOND_TICK_OUT,
    output logic                     ALARM0_FLAG_OUT,
    output logic                     ALARM1_FLAG_OUT,
    output logic                     WRITE_ENABLED_OUT,
    output logic                     IRQ_OUT
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [31:0]         alarm_reg [2];
    logic [1:0]          alarm_hit;
    logic [1:0]          alarm_flag;
    logic [SUBSEC_W-1:0] subsec_value;
    rta_lock_type        lock_state;
    rta_lock_type        next_lock;
    logic [NUM_EVT-1:0]  irq_status;
    logic [NUM_EVT-1:0]  irq_mask;
    logic [NUM_EVT-1:0]  event_pulse;
    logic                key_write;
    logic                alarm_write_try;
    logic                alarm_write_ok;
    logic                flags_write;
    logic                status_write;
    logic [31:0]         next_rdata;

    rta_cal_if cal ();

    // ****************************************************************
    // address decode
    // ****************************************************************

    // one compare shared by the write strobes and the alarm register select
    function automatic logic hits(input logic [ADDR_W-1:0] addr,
                                  input logic [7:0]        offset);
        hits = (addr == offset);
    endfunction

    // write strobes per register
    assign key_write       = WR_IN && hits(ADDR_IN, OFS_KEY);
    assign alarm_write_try = WR_IN && (hits(ADDR_IN, OFS_ALARM0) ||
                                       hits(ADDR_IN, OFS_ALARM1));
    // both the init state and an open key lock must hold
    assign alarm_write_ok  = alarm_write_try && INIT_STATE_IN &&
                             (lock_state == LOCK_OPEN);
    assign flags_write     = WR_IN && hits(ADDR_IN, OFS_FLAGS);
    assign status_write    = WR_IN && hits(ADDR_IN, OFS_IRQ_STATUS);

    // ****************************************************************
    // write protection key
    // ****************************************************************

    // only the low byte is a key; upper bits are ignored
    always_comb begin
        next_lock = lock_state;
        if (key_write) begin
            case (lock_state)
                LOCK_CLOSED: begin
                    next_lock = (WDATA_IN[KEY_W-1:0] == KEY_FIRST) ?
                                LOCK_HALF : LOCK_CLOSED;
                end
                LOCK_HALF: begin
                    next_lock = (WDATA_IN[KEY_W-1:0] == KEY_SECOND) ?
                                LOCK_OPEN : LOCK_CLOSED;
                end
                LOCK_OPEN: begin
                    // any further key write relocks, a first key restarts
                    next_lock = (WDATA_IN[KEY_W-1:0] == KEY_FIRST) ?
                                LOCK_HALF : LOCK_CLOSED;
                end
                default: begin
                    next_lock = LOCK_CLOSED;
                end
            endcase
        end
    end

    // lock state and its mirrored output
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            lock_state        <= LOCK_CLOSED;
            WRITE_ENABLED_OUT <= 1'b0;
        end else begin
            lock_state        <= next_lock;
            WRITE_ENABLED_OUT <= (next_lock == LOCK_OPEN);
        end
    end

    // ****************************************************************
    // alarm registers
    // ****************************************************************

    // backup domain only: a system reset must not disturb the alarms
    always_ff @(posedge CLK_IN or posedge BKP_RST_IN) begin
        if (BKP_RST_IN) begin
            alarm_reg[0] <= ALARM_RESET;
            alarm_reg[1] <= ALARM_RESET;
        end else if (alarm_write_ok) begin
            if (hits(ADDR_IN, OFS_ALARM0)) begin
                alarm_reg[0] <= WDATA_IN;
            end else begin
                alarm_reg[1] <= WDATA_IN;
            end
        end
    end

    // ****************************************************************
    // alarm comparison
    // ****************************************************************

    // calendar values are produced on this clock, so no synchroniser
    assign cal.time_now    = CAL_TIME_IN;
    assign cal.day_now     = CAL_DAY_IN;
    assign cal.weekday_now = CAL_WEEKDAY_IN;
    assign cal.update      = CAL_UPDATE_IN;

    // one comparator per alarm
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_match
            rta_alarm_match u_match (
                .alarm_in (alarm_reg[gi]),
                .cal      (cal.sink),
                .hit_out  (alarm_hit[gi])
            );
        end
    endgenerate

    // a match only counts on the update strobe, so one per second
    assign event_pulse[EVT_ALARM0]  = alarm_hit[0] && cal.update;
    assign event_pulse[EVT_ALARM1]  = alarm_hit[1] && cal.update;
    assign event_pulse[EVT_REFUSED] = alarm_write_try && !alarm_write_ok;

    // ****************************************************************
    // alarm flags
    // ****************************************************************

    // writing zero clears; a match in the same cycle wins
    generate
        for (gi = 0; gi < 2; gi++) begin : g_flag
            always_ff @(posedge CLK_IN or posedge RST_IN) begin
                if (RST_IN) begin
                    alarm_flag[gi] <= 1'b0;
                end else if (event_pulse[gi]) begin
                    alarm_flag[gi] <= 1'b1;
                end else if (flags_write && !WDATA_IN[gi]) begin
                    alarm_flag[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // flag outputs register the sticky flags ORed with the match pulses
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ALARM0_FLAG_OUT <= 1'b0;
            ALARM1_FLAG_OUT <= 1'b0;
        end else begin
            ALARM0_FLAG_OUT <= alarm_flag[0] || event_pulse[EVT_ALARM0];
            ALARM1_FLAG_OUT <= alarm_flag[1] || event_pulse[EVT_ALARM1];
        end
    end

    // ****************************************************************
    // interrupt status and mask
    // ****************************************************************

    // sticky bits, cleared by writing one; a new event wins over the clear
    generate
        for (gi = 0; gi < NUM_EVT; gi++) begin : g_irq
            always_ff @(posedge CLK_IN or posedge RST_IN) begin
                if (RST_IN) begin
                    irq_status[gi] <= 1'b0;
                end else if (event_pulse[gi]) begin
                    irq_status[gi] <= 1'b1;
                end else if (status_write && WDATA_IN[gi]) begin
                    irq_status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // mask register, one enable per status bit
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            irq_mask <= '0;
        end else if (WR_IN && hits(ADDR_IN, OFS_IRQ_MASK)) begin
            irq_mask <= WDATA_IN[NUM_EVT-1:0];
        end
    end

    // level output, one cycle behind the status bits
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= |(irq_status & irq_mask);
        end
    end

    // ****************************************************************
    // synchronous prescaler and sub-second value
    // ****************************************************************

    // fraction of a second is left to software: (factor - count) / (factor + 1)
    rta_subsec u_subsec (
        .clk_in        (CLK_IN),
        .bkp_rst_in    (BKP_RST_IN),
        .sys_rst_in    (RST_IN),
        .async_tick_in (ASYNC_TICK_IN),
        .init_in       (INIT_STATE_IN),
        .bypass_in     (SHADOW_BYPASS_IN),
        .factor_in     (SYNC_FACTOR_IN),
        .value_out     (subsec_value),
        .tick_out      (ONE_SECOND_TICK_OUT)
    );

    // ****************************************************************
    // read path
    // ****************************************************************

    // key register is write-only and unmapped offsets both read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (ADDR_IN)
            OFS_ALARM0: begin
                next_rdata = alarm_reg[0];
            end
            OFS_ALARM1: begin
                next_rdata = alarm_reg[1];
            end
            OFS_SUBSEC: begin
                // whole word only; upper half is always zero
                next_rdata = {16'h0000, subsec_value};
            end
            OFS_FLAGS: begin
                next_rdata = {30'h0000_0000, alarm_flag};
            end
            OFS_IRQ_STATUS: begin
                next_rdata = {29'h0000_0000, irq_status};
            end
            OFS_IRQ_MASK: begin
                next_rdata = {29'h0000_0000, irq_mask};
            end
            OFS_LOCK_STATUS: begin
                next_rdata = {29'h0000_0000, INIT_STATE_IN, lock_state};
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // data valid in the cycle after the read strobe only
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RDATA_OUT <= 32'h0000_0000;
        end else if (RD_IN) begin
            RDATA_OUT <= next_rdata;
        end else begin
            RDATA_OUT <= 32'h0000_0000;
        end
    end

endmodule : rta_top
`default_nettype wire

// ==== verification/rta_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module rta_top_asserts
    import rta_pkg::*;
(
    input wire logic              CLK_IN,
    input wire logic              RST_IN,
    input wire logic              BKP_RST_IN,
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic [31:0]       WDATA_IN,
    input wire logic              WR_IN,
    input wire logic              RD_IN,
    input wire logic              INIT_STATE_IN,
    input wire logic              SHADOW_BYPASS_IN,
    input wire logic              ASYNC_TICK_IN,
    input wire logic              CAL_UPDATE_IN,
    input wire logic [31:0]       RDATA_OUT,
    input wire logic              ONE_SECOND_TICK_OUT,
    input wire logic              ALARM0_FLAG_OUT,
    input wire logic              ALARM1_FLAG_OUT,
    input wire logic              WRITE_ENABLED_OUT
);
    logic tick_seen;

    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN || BKP_RST_IN);

    // shadow untouched since system reset; any tick may refill it
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            tick_seen <= 1'b0;
        end else if (ASYNC_TICK_IN) begin
            tick_seen <= 1'b1;
        end
    end

    // ****************************************************************
    // key sequence
    // ****************************************************************
    sequence key_write(logic [7:0] k);
        WR_IN && ADDR_IN == OFS_KEY && WDATA_IN[7:0] == k;
    endsequence
    sequence key_pair;
        key_write(KEY_FIRST) ##1 !WR_IN ##1 key_write(KEY_SECOND);
    endsequence

    a_key_unlocks: assert property (key_pair |-> ##[1:2] WRITE_ENABLED_OUT)
        else $error("lock stayed shut after key pair");
    a_bad_key_locks: assert property (WR_IN && ADDR_IN == OFS_KEY
        && WDATA_IN[7:0] != KEY_FIRST && WDATA_IN[7:0] != KEY_SECOND |-> ##2 !WRITE_ENABLED_OUT)
        else $error("wrong key left lock open");
    a_flag0_cause: assert property ($rose(ALARM0_FLAG_OUT)
        |-> $past(CAL_UPDATE_IN) || $past(CAL_UPDATE_IN, 2))
        else $error("alarm0 flag rose without update");
    a_flag1_cause: assert property ($rose(ALARM1_FLAG_OUT)
        |-> $past(CAL_UPDATE_IN) || $past(CAL_UPDATE_IN, 2))
        else $error("alarm1 flag rose without update");
    a_key_reads_zero: assert property (RD_IN && ADDR_IN == OFS_KEY
        |=> RDATA_OUT == 32'h0000_0000)
        else $error("key register read nonzero");
    a_subsec_upper: assert property (RD_IN && ADDR_IN == OFS_SUBSEC
        |=> RDATA_OUT[31:16] == 16'h0000)
        else $error("sub-second upper bits nonzero");
    a_subsec_cleared: assert property (RD_IN && ADDR_IN == OFS_SUBSEC && !SHADOW_BYPASS_IN
        && !tick_seen && !ASYNC_TICK_IN |=> RDATA_OUT == 32'h0000_0000)
        else $error("sub-second not zero after reset");
    a_tick_source: assert property (ONE_SECOND_TICK_OUT
        |-> $past(ASYNC_TICK_IN) && !$past(INIT_STATE_IN))
        else $error("second tick without prescaler tick");
endmodule // rta_top_asserts

bind rta_top rta_top_asserts i_rta_top_asserts (.CLK_IN, .RST_IN, .BKP_RST_IN, .ADDR_IN,
    .WDATA_IN, .WR_IN, .RD_IN, .INIT_STATE_IN, .SHADOW_BYPASS_IN, .ASYNC_TICK_IN,
    .CAL_UPDATE_IN, .RDATA_OUT, .ONE_SECOND_TICK_OUT, .ALARM0_FLAG_OUT, .ALARM1_FLAG_OUT,
    .WRITE_ENABLED_OUT);
`default_nettype wire

// ==== verification/rta_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module rta_top_tb
    import rta_pkg::*;
;
    logic                clk, rst, bkp, wr, rd, init, bypass, atick, cal_upd;
    logic                sec_tick, flag0, flag1, wr_en, irq;
    logic [ADDR_W-1:0]   addr;
    logic [31:0]         wdata, rdata;
    logic [FACTOR_W-1:0] factor;
    logic [22:0]         cal_time;
    logic [5:0]          cal_day;
    logic [2:0]          cal_wd;
    int                  err_total, num_checks, tick_count;
    localparam logic [31:0] AM = 32'h1551_4237;
    localparam logic [22:0] TM = 23'h51_4237;

    rta_top i_rta_top (.CLK_IN(clk), .RST_IN(rst), .BKP_RST_IN(bkp), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .INIT_STATE_IN(init),
        .SHADOW_BYPASS_IN(bypass), .ASYNC_TICK_IN(atick), .SYNC_FACTOR_IN(factor),
        .CAL_TIME_IN(cal_time), .CAL_DAY_IN(cal_day), .CAL_WEEKDAY_IN(cal_wd),
        .CAL_UPDATE_IN(cal_upd), .RDATA_OUT(rdata), .ONE_SECOND_TICK_OUT(sec_tick),
        .ALARM0_FLAG_OUT(flag0), .ALARM1_FLAG_OUT(flag1), .WRITE_ENABLED_OUT(wr_en),
        .IRQ_OUT(irq));

    // ****************************************************************
    // access tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(name, exp, rdata);
    endtask
    task automatic unlock;
        wr_reg(OFS_KEY, {24'h0, KEY_FIRST});
        wr_reg(OFS_KEY, {24'h0, KEY_SECOND});
        idle(2);
    endtask
    task automatic atick_pulse;
        @(posedge clk);
        atick <= 1'b1;
        @(posedge clk);
        atick <= 1'b0;
    endtask
    task automatic pulse_reset(input logic sys);
        @(posedge clk);
        if (sys) rst <= 1'b1; else bkp <= 1'b1;
        idle(2);
        rst <= 1'b0;
        bkp <= 1'b0;
    endtask
    // program both alarms, present one calendar update, then clear flags
    task automatic alarm_case(input logic [31:0] a0, input logic [31:0] a1,
                              input logic [22:0] t, input logic [5:0] d,
                              input logic [2:0] w, input logic [1:0] exp);
        wr_reg(OFS_ALARM0, a0);
        wr_reg(OFS_ALARM1, a1);
        @(posedge clk);
        cal_time <= t;
        cal_day <= d;
        cal_wd <= w;
        cal_upd <= 1'b1;
        @(posedge clk);
        cal_upd <= 1'b0;
        idle(2);
        check("alarm pins", {30'h0, exp}, {30'h0, flag1, flag0});
        rd_reg(OFS_FLAGS, {30'h0, exp}, "flags");
        wr_reg(OFS_FLAGS, 32'h0);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ****************************************************************
    // clock, watchdog, tick counter
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // whole run is a few hundred cycles; generous margin
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("[FAIL] watchdog expected finish seen hang");
        final_report();
    end
    always @(posedge clk) if (sec_tick === 1'b1) tick_count++;

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        {rst, bkp} = 2'b11;
        {wr, rd, init, bypass, atick, cal_upd} = '0;
        {addr, wdata, factor, cal_time, cal_day, cal_wd} = '0;
        {err_total, num_checks, tick_count} = '0;
        repeat (4) @(posedge clk);
        {rst, bkp} <= 2'b00;
        rd_reg(OFS_ALARM0, 32'h0, "alarm0 reset");
        rd_reg(OFS_ALARM1, 32'h0, "alarm1 reset");
        rd_reg(OFS_KEY, 32'h0, "key read");
        rd_reg(OFS_SUBSEC, 32'h0, "subsec reset");
        rd_reg(8'h00, 32'h0, "unmapped");
        $display("test reset done");
        // protection: refused writes, irq on refusal, key lock
        @(posedge clk) init <= 1'b1;
        wr_reg(OFS_ALARM0, 32'h1234_5678);
        rd_reg(OFS_ALARM0, 32'h0, "alarm0 locked");
        rd_reg(OFS_IRQ_STATUS, 32'h4, "irq status");
        check("irq masked", 32'h0, {31'h0, irq});
        wr_reg(OFS_IRQ_MASK, 32'h4);
        idle(2);
        check("irq raised", 32'h1, {31'h0, irq});
        wr_reg(OFS_IRQ_STATUS, 32'h4);
        idle(2);
        check("irq cleared", 32'h0, {31'h0, irq});
        unlock();
        check("write enabled", 32'h1, {31'h0, wr_en});
        @(posedge clk) init <= 1'b0;
        wr_reg(OFS_ALARM0, 32'h1234_5678);
        rd_reg(OFS_ALARM0, 32'h0, "alarm0 not init");
        @(posedge clk) init <= 1'b1;
        wr_reg(OFS_ALARM0, 32'h2345_1234);
        rd_reg(OFS_ALARM0, 32'h2345_1234, "alarm0 written");
        wr_reg(OFS_KEY, 32'h0000_0011);
        idle(2);
        check("relocked", 32'h0, {31'h0, wr_en});
        wr_reg(OFS_ALARM0, 32'h0);
        rd_reg(OFS_ALARM0, 32'h2345_1234, "alarm0 relocked");
        $display("test protection done");
        unlock();
        alarm_case(AM, 0, TM, 6'h15, 3'd0, 2'b01);
        alarm_case(AM, 0, TM, 6'h16, 3'd0, 2'b00);
        alarm_case(32'h9551_4237, 0, TM, 6'h16, 3'd0, 2'b01);
        alarm_case(AM, 0, 23'h11_4237, 6'h15, 3'd0, 2'b00);
        alarm_case(AM, 0, 23'h41_4237, 6'h15, 3'd0, 2'b00);
        alarm_case(32'h15D1_4237, 0, 23'h01_4237, 6'h15, 3'd0, 2'b01);
        alarm_case(AM, 0, 23'h51_4337, 6'h15, 3'd0, 2'b00);
        alarm_case(32'h1551_C237, 0, 23'h51_4337, 6'h15, 3'd0, 2'b01);
        alarm_case(AM, 0, 23'h51_4238, 6'h15, 3'd0, 2'b00);
        alarm_case(32'h1551_42B7, 0, 23'h51_4238, 6'h15, 3'd0, 2'b01);
        alarm_case(32'h6351_4237, 0, TM, 6'h15, 3'd3, 2'b01);
        alarm_case(32'h6351_4237, 0, TM, 6'h15, 3'd4, 2'b00);
        alarm_case(0, AM, TM, 6'h15, 3'd0, 2'b10);
        idle(3);
        rd_reg(OFS_FLAGS, 32'h0, "no update no flag");
        $display("test alarm done");
        // prescaler factor 5: reload from zero, then every sixth tick
        @(posedge clk);
        init <= 1'b0;
        bypass <= 1'b1;
        factor <= 15'd5;
        tick_count = 0;
        atick_pulse();
        rd_reg(OFS_SUBSEC, 32'h5, "subsec reload");
        repeat (12) atick_pulse();
        idle(2);
        check("second ticks", 32'd3, tick_count);
        pulse_reset(1'b1);
        rd_reg(OFS_SUBSEC, 32'h5, "subsec bypass kept");
        @(posedge clk) bypass <= 1'b0;
        rd_reg(OFS_SUBSEC, 32'h0, "subsec shadow reset");
        rd_reg(OFS_ALARM1, AM, "alarm1 system reset");
        atick_pulse();
        rd_reg(OFS_SUBSEC, 32'h5, "subsec shadow");
        @(posedge clk) bypass <= 1'b1;
        rd_reg(OFS_SUBSEC, 32'h4, "subsec live");
        $display("test subsecond done");
        pulse_reset(1'b0);
        rd_reg(OFS_ALARM1, 32'h0, "alarm1 backup reset");
        rd_reg(OFS_SUBSEC, 32'h0, "subsec backup reset");
        $display("test backup done");
        final_report();
    end
endmodule // rta_top_tb
`default_nettype wire
